// [core/ea_pkg.sv]
package ea_pkg;

	localparam int ADDR_W = 16;
	localparam int BYTE_W = 8;

	// Program-counter advance per instruction length.
	localparam logic [15:0] PC_STEP_1 = 16'h0001;
	localparam logic [15:0] PC_STEP_2 = 16'h0002;
	localparam logic [15:0] PC_STEP_3 = 16'h0003;

	// Operand location in the instruction stream.
	localparam logic [15:0] OPND_OFS_1 = 16'h0001;
	localparam logic [7:0]  ZERO_PAGE  = 8'h00;

	// Reset values of the output flops.
	localparam logic [15:0] ADDR_RST = 16'h0000;
	localparam logic [15:0] PC_RST   = 16'h0000;

	typedef enum logic [3:0] {
		opcode_only_mode       = 4'h0,
		literal_operand_mode   = 4'h1,
		zero_page_mode         = 4'h2,
		full_address_mode      = 4'h3,
		pointer_no_offset_mode = 4'h4,
		pointer_plus_byte_mode = 4'h5,
		pointer_plus_word_mode = 4'h6,
		branch_offset_mode     = 4'h7,
		single_bit_write_mode  = 4'h8,
		single_bit_branch_mode = 4'h9
	} mode_e;

	// One decode request: mode, operand bytes and current state.
	typedef struct packed {
		mode_e      mode;
		logic [7:0] opcode;
		logic [7:0] byte1;
		logic [7:0] byte2;
		logic [7:0] index;
		logic [15:0] pc;
		logic       cond;
		logic [7:0] tested;
	} ea_req_s;

	// One decode answer.
	typedef struct packed {
		logic [15:0] addr;
		logic        addr_used;
		logic [15:0] next_pc;
		logic [1:0]  length;
		logic [2:0]  bit_num;
		logic        carry_wr;
		logic        carry_val;
	} ea_rsp_s;

endpackage

// [core/effective_address_generator.sv]
module effective_address_generator (
	// Clock and reset.
	input  wire logic           CORE_CLK,
	input  wire logic           RSTN,
	// Decode request.
	input  wire logic           REQ_VALID,
	input  ea_pkg::ea_req_s     REQ,
	// Decode answer.
	output logic                RSP_VALID,
	output ea_pkg::ea_rsp_s     RSP
);

	ea_pkg::ea_rsp_s rsp_d;
	ea_pkg::ea_rsp_s rsp_q;
	logic            valid_q;
	logic            bit_state;
	logic            bit_match;

	// Sign extension is shared by both branch forms.
	function automatic logic [15:0] sext(input logic [7:0] b);
		sext = {{8{b[7]}}, b};
	endfunction

	// Opcode bit 0 selects clear/branch-on-clear, bits 3:1 the bit number.
	assign bit_state = REQ.tested[REQ.opcode[3:1]];
	assign bit_match = bit_state ^ REQ.opcode[0];

	always_comb begin
		logic [8:0] low_sum;
		low_sum = 9'(REQ.index) + 9'(REQ.byte1);
		rsp_d = '0;
		rsp_d.bit_num = REQ.opcode[3:1];
		unique case (REQ.mode)
			ea_pkg::opcode_only_mode: begin
				rsp_d.next_pc = REQ.pc + ea_pkg::PC_STEP_1;
				rsp_d.length = 2'd1;
			end
			ea_pkg::literal_operand_mode: begin
				rsp_d.addr = REQ.pc + ea_pkg::OPND_OFS_1;
				rsp_d.addr_used = 1'b1;
				rsp_d.next_pc = REQ.pc + ea_pkg::PC_STEP_2;
				rsp_d.length = 2'd2;
			end
			ea_pkg::zero_page_mode: begin
				rsp_d.addr = {ea_pkg::ZERO_PAGE, REQ.byte1};
				rsp_d.addr_used = 1'b1;
				rsp_d.next_pc = REQ.pc + ea_pkg::PC_STEP_2;
				rsp_d.length = 2'd2;
			end
			ea_pkg::full_address_mode: begin
				rsp_d.addr = {REQ.byte1, REQ.byte2};
				rsp_d.addr_used = 1'b1;
				rsp_d.next_pc = REQ.pc + ea_pkg::PC_STEP_3;
				rsp_d.length = 2'd3;
			end
			ea_pkg::pointer_no_offset_mode: begin
				rsp_d.addr = {ea_pkg::ZERO_PAGE, REQ.index};
				rsp_d.addr_used = 1'b1;
				rsp_d.next_pc = REQ.pc + ea_pkg::PC_STEP_1;
				rsp_d.length = 2'd1;
			end
			ea_pkg::pointer_plus_byte_mode: begin
				rsp_d.addr = {7'h00, low_sum};
				rsp_d.addr_used = 1'b1;
				rsp_d.next_pc = REQ.pc + ea_pkg::PC_STEP_2;
				rsp_d.length = 2'd2;
			end
			ea_pkg::pointer_plus_word_mode: begin
				// The high-byte add drops its own carry, so the sum wraps.
				rsp_d.addr = {REQ.byte1, REQ.byte2}
					+ {8'h00, REQ.index};
				rsp_d.addr_used = 1'b1;
				rsp_d.next_pc = REQ.pc + ea_pkg::PC_STEP_3;
				rsp_d.length = 2'd3;
			end
			ea_pkg::branch_offset_mode: begin
				rsp_d.next_pc = REQ.pc + ea_pkg::PC_STEP_2
					+ (REQ.cond ? sext(REQ.byte1) : 16'h0000);
				rsp_d.length = 2'd2;
			end
			ea_pkg::single_bit_write_mode: begin
				rsp_d.addr = {ea_pkg::ZERO_PAGE, REQ.byte1};
				rsp_d.addr_used = 1'b1;
				rsp_d.next_pc = REQ.pc + ea_pkg::PC_STEP_2;
				rsp_d.length = 2'd2;
			end
			ea_pkg::single_bit_branch_mode: begin
				rsp_d.addr = {ea_pkg::ZERO_PAGE, REQ.byte1};
				rsp_d.addr_used = 1'b1;
				rsp_d.next_pc = REQ.pc + ea_pkg::PC_STEP_3
					+ (bit_match ? sext(REQ.byte2) : 16'h0000);
				rsp_d.length = 2'd3;
				rsp_d.carry_wr = 1'b1;
				rsp_d.carry_val = bit_state;
			end
			default: begin
				// Illegal mode codes decode as a one-byte no-operand step.
				rsp_d.next_pc = REQ.pc + ea_pkg::PC_STEP_1;
				rsp_d.length = 2'd1;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			valid_q <= 1'b0;
		end else begin
			valid_q <= REQ_VALID;
		end
	end

	// Answer holds its last value while no request is made.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rsp_q <= '0;
		end else if (REQ_VALID) begin
			rsp_q <= rsp_d;
		end
	end

	assign RSP_VALID = valid_q;
	assign RSP = rsp_q;

	a_full_addr: assert property (@(posedge CORE_CLK)
		disable iff (!RSTN)
		REQ_VALID && REQ.mode == ea_pkg::full_address_mode |=>
		RSP.addr == {$past(REQ.byte1), $past(REQ.byte2)}
		&& RSP.next_pc == $past(REQ.pc) + 16'h0003)
		else $error("full address answer wrong");

	a_zero_page: assert property (@(posedge CORE_CLK)
		disable iff (!RSTN)
		REQ_VALID && (REQ.mode == ea_pkg::zero_page_mode
		|| REQ.mode == ea_pkg::single_bit_write_mode) |=>
		RSP.addr[15:8] == 8'h00 && RSP.addr[7:0] == $past(REQ.byte1))
		else $error("zero page address wrong");

	a_literal_pc: assert property (@(posedge CORE_CLK)
		disable iff (!RSTN)
		REQ_VALID && REQ.mode == ea_pkg::literal_operand_mode |=>
		RSP.addr + 16'h0001 == RSP.next_pc
		&& RSP.addr == $past(REQ.pc) + 16'h0001)
		else $error("literal operand address wrong");

	a_ptr_none: assert property (@(posedge CORE_CLK)
		disable iff (!RSTN)
		REQ_VALID && REQ.mode == ea_pkg::pointer_no_offset_mode |=>
		RSP.addr == {8'h00, $past(REQ.index)} && RSP.length == 2'd1)
		else $error("pointer address wrong");

	a_ptr_byte: assert property (@(posedge CORE_CLK)
		disable iff (!RSTN)
		REQ_VALID && REQ.mode == ea_pkg::pointer_plus_byte_mode |=>
		RSP.addr == 16'($past(REQ.index)) + 16'($past(REQ.byte1))
		&& RSP.addr <= 16'h01fe)
		else $error("pointer plus byte wrong");

	a_ptr_word: assert property (@(posedge CORE_CLK)
		disable iff (!RSTN)
		REQ_VALID && REQ.mode == ea_pkg::pointer_plus_word_mode |=>
		RSP.addr[7:0] == 8'($past(REQ.index) + $past(REQ.byte2)))
		else $error("pointer plus word low byte wrong");

	a_ptr_word_wrap: assert property (@(posedge CORE_CLK)
		disable iff (!RSTN)
		REQ_VALID && REQ.mode == ea_pkg::pointer_plus_word_mode |=>
		RSP.addr == {$past(REQ.byte1), $past(REQ.byte2)}
		+ 16'($past(REQ.index)))
		else $error("pointer plus word sum wrong");

	a_branch_nt: assert property (@(posedge CORE_CLK)
		disable iff (!RSTN)
		REQ_VALID && REQ.mode == ea_pkg::branch_offset_mode && !REQ.cond
		|=> RSP.next_pc == $past(REQ.pc) + 16'h0002)
		else $error("untaken branch target wrong");

	a_branch_taken: assert property (@(posedge CORE_CLK)
		disable iff (!RSTN)
		REQ_VALID && REQ.mode == ea_pkg::branch_offset_mode && REQ.cond
		|=> RSP.next_pc == $past(REQ.pc) + 16'h0002
		+ {{8{$past(REQ.byte1[7])}}, $past(REQ.byte1)})
		else $error("taken branch target wrong");

	a_bit_write: assert property (@(posedge CORE_CLK)
		disable iff (!RSTN)
		REQ_VALID && REQ.mode == ea_pkg::single_bit_write_mode |=>
		RSP.bit_num == $past(REQ.opcode[3:1])
		&& RSP.addr == {8'h00, $past(REQ.byte1)})
		else $error("bit write answer wrong");

	a_bit_branch_addr: assert property (@(posedge CORE_CLK)
		disable iff (!RSTN)
		REQ_VALID && REQ.mode == ea_pkg::single_bit_branch_mode |=>
		RSP.addr == {8'h00, $past(REQ.byte1)} && RSP.length == 2'd3)
		else $error("bit branch address wrong");

	a_bit_branch_skip: assert property (@(posedge CORE_CLK)
		disable iff (!RSTN)
		REQ_VALID && REQ.mode == ea_pkg::single_bit_branch_mode
		&& REQ.tested[REQ.opcode[3:1]] == REQ.opcode[0]
		|=> RSP.next_pc == $past(REQ.pc) + 16'h0003)
		else $error("untaken bit branch target wrong");

	a_bit_carry: assert property (@(posedge CORE_CLK)
		disable iff (!RSTN)
		REQ_VALID && REQ.mode == ea_pkg::single_bit_branch_mode |=>
		RSP.carry_wr && RSP.carry_val
		== $past(REQ.tested[REQ.opcode[3:1]]))
		else $error("tested bit not copied to carry");

	a_opcode_only: assert property (@(posedge CORE_CLK)
		disable iff (!RSTN)
		REQ_VALID && REQ.mode == ea_pkg::opcode_only_mode |=>
		!RSP.addr_used && RSP.length == 2'd1
		&& RSP.next_pc == $past(REQ.pc) + 16'h0001)
		else $error("opcode only answer wrong");

	// Codes past the last mode must never start a memory access.
	a_illegal_mode: assert property (@(posedge CORE_CLK)
		disable iff (!RSTN)
		REQ_VALID && REQ.mode > ea_pkg::single_bit_branch_mode |=>
		!RSP.addr_used && RSP.length == 2'd1)
		else $error("illegal mode answer wrong");

	a_length: assert property (@(posedge CORE_CLK)
		disable iff (!RSTN)
		RSP_VALID |-> RSP.length != 2'd0)
		else $error("instruction length out of range");

endmodule

// [dv/ea_mem_model.sv]
// Program memory seen from the fetch side: it returns the two operand bytes
// that follow the opcode. Address arithmetic is 16 bits, so fetches past
// the top of memory wrap to the bottom.
module ea_mem_model (
	// Fetch address.
	input  wire logic [15:0] pc,
	// Operand bytes.
	output logic      [7:0]  b1,
	output logic      [7:0]  b2
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] m [0:65535];
	assign b1 = m[pc + 16'h0001];
	assign b2 = m[pc + 16'h0002];
endmodule

// [dv/effective_address_generator_tb.sv]
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
	$display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module effective_address_generator_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic              CORE_CLK = 1'b0;
	logic              RSTN = 1'b0;
	logic              REQ_VALID = 1'b0;
	ea_pkg::ea_req_s   REQ = '0;
	logic              RSP_VALID;
	ea_pkg::ea_rsp_s   RSP;
	logic [15:0]       pc_m = 16'h0000;
	logic [7:0]        b1;
	logic [7:0]        b2;
	int                num_errors = 0;
	int                checks = 0;
	ea_pkg::ea_rsp_s   held = '0;
	logic [3:0]        cur_md = 4'h0;
	effective_address_generator uut (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
		.REQ_VALID(REQ_VALID), .REQ(REQ), .RSP_VALID(RSP_VALID), .RSP(RSP));
	ea_mem_model mem_u (.pc(pc_m), .b1(b1), .b2(b2));
	initial begin
		forever #4 CORE_CLK = ~CORE_CLK;
	end
	task automatic ld(input logic [15:0] a, input logic [7:0] x, y);
		mem_u.m[a + 16'h0001] = x;
		mem_u.m[a + 16'h0002] = y;
	endtask
	// One request every other cycle. The request rises two ns after an edge;
	// the edge before it must show the last answer still held, valid low.
	task automatic start(input logic [3:0] md, input logic [7:0] op, ix,
		input logic [15:0] pc, input logic cnd, input logic [7:0] tst);
		pc_m = pc;
		cur_md = md;
		@(posedge CORE_CLK);
		#2;
		`CHK(RSP_VALID, 1'b0)
		`CHK(RSP, held)
		REQ = '{ea_pkg::mode_e'(md), op, b1, b2, ix, pc, cnd, tst};
		REQ_VALID = 1'b1;
	endtask
	// The answer is judged two ns after the edge that takes the request.
	task automatic judge(input logic [15:0] ea, np, input logic [1:0] len);
		@(posedge CORE_CLK);
		#2;
		REQ_VALID = 1'b0;
		`CHK(RSP_VALID, 1'b1)
		`CHK({RSP.addr, RSP.next_pc, RSP.length}, {ea, np, len})
		`CHK(RSP.addr_used, !(cur_md inside {4'h0, 4'h7}) && cur_md < 4'ha)
		held = RSP;
	endtask
	task automatic t_short();
		start(4'h0, 8'h9d, 8'h11, 16'h0100, 1'b0, 8'h00);
		judge(16'h0000, 16'h0101, 2'd1);
		start(4'h4, 8'hf7, 8'hf3, 16'h0100, 1'b0, 8'h00);
		judge(16'h00f3, 16'h0101, 2'd1);
		start(4'hf, 8'h00, 8'h00, 16'hffff, 1'b0, 8'h00);
		judge(16'h0000, 16'h0000, 2'd1);
		$display("short forms done");
	endtask
	task automatic t_operand();
		ld(16'h0200, 8'hab, 8'hcd);
		start(4'h1, 8'ha6, 8'h00, 16'h0200, 1'b0, 8'h00);
		judge(16'h0201, 16'h0202, 2'd2);
		start(4'h2, 8'hb6, 8'h00, 16'h0200, 1'b0, 8'h00);
		judge(16'h00ab, 16'h0202, 2'd2);
		start(4'h3, 8'hc6, 8'h00, 16'h0200, 1'b0, 8'h00);
		judge(16'habcd, 16'h0203, 2'd3);
		start(4'h8, 8'h0b, 8'h00, 16'h0200, 1'b0, 8'h00);
		judge(16'h00ab, 16'h0202, 2'd2);
		`CHK(RSP.bit_num, 3'd5)
		$display("operand forms done");
	endtask
	task automatic t_indexed();
		start(4'h5, 8'he6, 8'hf3, 16'h0200, 1'b0, 8'h00);
		judge(16'h019e, 16'h0202, 2'd2);
		start(4'h6, 8'hd6, 8'hf3, 16'h0200, 1'b0, 8'h00);
		judge(16'hacc0, 16'h0203, 2'd3);
		ld(16'h0300, 8'hff, 8'hff);
		start(4'h5, 8'he6, 8'hff, 16'h0300, 1'b0, 8'h00);
		judge(16'h01fe, 16'h0302, 2'd2);
		start(4'h6, 8'hd6, 8'h02, 16'h0300, 1'b0, 8'h00);
		judge(16'h0001, 16'h0303, 2'd3);
		$display("indexed forms done");
	endtask
	// A reset in mid-run must clear a held answer at once.
	task automatic t_reset();
		@(posedge CORE_CLK);
		#2;
		RSTN = 1'b0;
		#1;
		`CHK({RSP_VALID, RSP}, '0)
		held = '0;
		@(posedge CORE_CLK);
		#2;
		RSTN = 1'b1;
		$display("mid-run reset done");
	endtask
	task automatic t_branch();
		ld(16'h0400, 8'h80, 8'h00);
		ld(16'h0500, 8'h7f, 8'h00);
		ld(16'hfffe, 8'h05, 8'h00);
		start(4'h7, 8'h20, 8'h00, 16'h0400, 1'b1, 8'h00);
		judge(16'h0000, 16'h0382, 2'd2);
		start(4'h7, 8'h20, 8'h00, 16'h0400, 1'b0, 8'h00);
		judge(16'h0000, 16'h0402, 2'd2);
		start(4'h7, 8'h20, 8'h00, 16'h0500, 1'b1, 8'h00);
		judge(16'h0000, 16'h0581, 2'd2);
		start(4'h7, 8'h20, 8'h00, 16'hfffe, 1'b1, 8'h00);
		judge(16'h0000, 16'h0005, 2'd2);
		$display("branches done");
	endtask
	task automatic t_bit_branch();
		ld(16'h0600, 8'h40, 8'hfc);
		start(4'h9, 8'h06, 8'h00, 16'h0600, 1'b0, 8'h08);
		judge(16'h0040, 16'h05ff, 2'd3);
		`CHK({RSP.carry_wr, RSP.carry_val}, 2'b11)
		start(4'h9, 8'h06, 8'h00, 16'h0600, 1'b0, 8'hf7);
		judge(16'h0040, 16'h0603, 2'd3);
		`CHK({RSP.carry_wr, RSP.carry_val}, 2'b10)
		start(4'h9, 8'h0f, 8'h00, 16'h0600, 1'b0, 8'h7f);
		judge(16'h0040, 16'h05ff, 2'd3);
		`CHK({RSP.carry_wr, RSP.carry_val, RSP.bit_num}, 5'b10111)
		$display("bit branches done");
	endtask
	task automatic finish_test();
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// About twenty requests at two cycles each plus two resets; the limit
	// leaves ample slack.
	initial begin
		#5000;
		num_errors++;
		finish_test();
	end
	initial begin
		repeat (16) @(posedge CORE_CLK);
		`CHK({RSP_VALID, RSP}, '0)
		#2;
		RSTN = 1'b1;
		t_short();
		t_operand();
		t_indexed();
		t_reset();
		t_branch();
		t_bit_branch();
		finish_test();
	end
endmodule
